/* cise_alu.sv */
// Combinational data path of the execution core: result and status flags.
// Assumes the caller registers everything it produces.
`timescale 1ns/10ps
`default_nettype none

module cise_alu
	import cise_pkg::*;
(
	input  wire cise_op_e         op,
	input  wire logic [ACC_W-1:0] acc,
	input  wire logic [ACC_W-1:0] lit,
	input  wire logic [ACC_W-1:0] fdata,
	output logic      [ACC_W-1:0] result,
	output logic                  zero,
	output logic                  no_borrow,
	output logic                  half_nb,
	output logic                  upd_z,
	output logic                  upd_c
);

	// Returns {no_borrow, difference} for a - b
	function automatic logic [ACC_W:0] sub_nb(input logic [ACC_W-1:0] a,
	                                          input logic [ACC_W-1:0] b);
		logic [ACC_W:0] d;
		d = {1'b0, a} - {1'b0, b};
		return {~d[ACC_W], d[ACC_W-1:0]};
	endfunction

	logic [ACC_W-1:0] opnd;
	logic [ACC_W:0]   sub_r;

	always_comb begin
		opnd      = (op == OP_LIT_MINUS || op == OP_LIT_XOR) ? lit : fdata;
		sub_r     = sub_nb(opnd, acc);
		result    = acc;
		no_borrow = FLAG_CLR;
		half_nb   = FLAG_CLR;
		upd_z     = 1'b0;
		upd_c     = 1'b0;
		case (op)
			OP_CLEAR_ACC: begin
				result = ACC_ZERO;
				upd_z  = 1'b1;
			end
			OP_LIT_MINUS, OP_REG_MINUS: begin
				result    = sub_r[ACC_W-1:0];
				no_borrow = sub_r[ACC_W];
				half_nb   = (opnd[NIB_W-1:0] >= acc[NIB_W-1:0]);
				upd_z     = 1'b1;
				upd_c     = 1'b1;
			end
			OP_LIT_XOR, OP_REG_XOR: begin
				result = acc ^ opnd;
				upd_z  = 1'b1;
			end
			OP_NIBBLE_SWAP: begin
				result = {fdata[NIB_W-1:0], fdata[ACC_W-1:NIB_W]};
			end
			default: begin
				result = acc;
			end
		endcase
		zero = (result == ACC_ZERO);
	end

endmodule

`default_nettype wire

/* cise_core.sv */
// Execution core for a subset of an 8-bit controller's instructions.
// Assumes one instruction offered per cycle with its file operand already read.
// Function
// - Clear accumulator loads zero, sets zero flag
// - Call pushes next address onto stack top
// - Call target fills PC low, latch fills high
// - Call takes two cycles, flags unchanged
// - Watchdog kick clears counter and prescaler
// - Watchdog kick sets timeout and sleep flags
// - Literal minus accumulator into accumulator, all three flags
// - Literal xor accumulator, into accumulator, Z only
// - Register minus accumulator updates borrow, half borrow, zero
// - Register xor accumulator updates Z only
// - Destination bit picks accumulator or register
// - Nibble swap exchanges halves, no flags
`timescale 1ns/10ps
`default_nettype none

module cise_core
	import cise_pkg::*;
(
	input  wire logic                CORE_CLK,
	input  wire logic                RST_N,
	input  wire logic                INSTR_VALID,
	input  wire cise_op_e            INSTR_OP,
	input  wire logic [ACC_W-1:0]    INSTR_LIT,
	input  wire logic [TGT_W-1:0]    INSTR_TARGET,
	input  wire logic [FADDR_W-1:0]  INSTR_FADDR,
	input  wire logic                INSTR_DEST,
	input  wire logic [ACC_W-1:0]    FILE_RDATA,
	input  wire logic [LATCH_W-1:0]  PC_UPPER_LATCH,
	output logic      [ACC_W-1:0]    ACC,
	output logic      [PC_W-1:0]     PC,
	output logic      [PC_W-1:0]     STACK_TOP,
	output logic                     STACK_PUSH,
	output logic                     BUSY,
	output logic                     ZERO_FLAG,
	output logic                     BORROW_OUT_BIT,
	output logic                     HALF_BORROW_BIT,
	output logic                     TIMEOUT_FLAG,
	output logic                     SLEEP_FLAG,
	output logic                     WDT_CLEAR,
	output logic                     WDT_PRESCALER_CLEAR,
	output logic                     FILE_WE,
	output logic      [FADDR_W-1:0]  FILE_WADDR,
	output logic      [ACC_W-1:0]    FILE_WDATA
);

	// ----------------------------------------
	// State
	// ----------------------------------------
	cise_state_e        state_q, state_d;
	logic [ACC_W-1:0]   acc_q, acc_d;
	logic [PC_W-1:0]    pc_q, pc_d;
	logic [PC_W-1:0]    rtn_q, rtn_d;
	logic               push_q, push_d;
	logic               busy_q, busy_d;
	logic               z_q, z_d;
	logic               c_q, c_d;
	logic               hb_q, hb_d;
	logic               to_q, to_d;
	logic               slp_q, slp_d;
	logic               wdt_q, wdt_d;
	logic               fwe_q, fwe_d;
	logic [FADDR_W-1:0] fwa_q, fwa_d;
	logic [ACC_W-1:0]   fwd_q, fwd_d;

	logic               take;
	logic [ACC_W-1:0]   alu_res;
	logic               alu_z;
	logic               alu_nb;
	logic               alu_hnb;
	logic               alu_upd_z;
	logic               alu_upd_c;

	cise_alu i_cise_alu (
		.op        (INSTR_OP),
		.acc       (acc_q),
		.lit       (INSTR_LIT),
		.fdata     (FILE_RDATA),
		.result    (alu_res),
		.zero      (alu_z),
		.no_borrow (alu_nb),
		.half_nb   (alu_hnb),
		.upd_z     (alu_upd_z),
		.upd_c     (alu_upd_c)
	);

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	// Instructions offered in the second call cycle are dropped, not queued
	assign take = INSTR_VALID && (state_q == ST_EXEC);

	always_comb begin
		state_d = state_q;
		acc_d   = acc_q;
		pc_d    = pc_q;
		rtn_d   = rtn_q;
		push_d  = 1'b0;
		z_d     = z_q;
		c_d     = c_q;
		hb_d    = hb_q;
		to_d    = to_q;
		slp_d   = slp_q;
		wdt_d   = 1'b0;
		fwe_d   = 1'b0;
		fwa_d   = fwa_q;
		fwd_d   = fwd_q;
		case (state_q)
			ST_EXEC: begin
				if (take) begin
					pc_d = pc_q + PC_STEP;
					if (alu_upd_z) begin
						z_d = alu_z;
					end
					if (alu_upd_c) begin
						c_d  = alu_nb;
						hb_d = alu_hnb;
					end
					case (INSTR_OP)
						OP_CLEAR_ACC, OP_LIT_MINUS, OP_LIT_XOR: begin
							acc_d = alu_res;
						end
						OP_REG_MINUS, OP_REG_XOR, OP_NIBBLE_SWAP: begin
							if (INSTR_DEST == DEST_FILE) begin
								fwe_d = 1'b1;
								fwa_d = INSTR_FADDR;
								fwd_d = alu_res;
							end else begin
								acc_d = alu_res;
							end
						end
						OP_CALL: begin
							rtn_d   = pc_q + PC_STEP;
							push_d  = 1'b1;
							pc_d    = {PC_UPPER_LATCH[LATCH_HI:LATCH_LO], INSTR_TARGET};
							state_d = ST_CALL2;
						end
						OP_KICK_WDT: begin
							wdt_d = 1'b1;
							to_d  = 1'b1;
							slp_d = 1'b1;
						end
						default: begin
							pc_d = pc_q + PC_STEP;
						end
					endcase
				end
			end
			ST_CALL2: begin
				state_d = ST_EXEC;
			end
			default: begin
				state_d = ST_EXEC;
			end
		endcase
		busy_d = (state_d == ST_CALL2);
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			state_q <= ST_EXEC;
			acc_q   <= ACC_RST;
			pc_q    <= PC_RST;
			rtn_q   <= PC_RST;
			push_q  <= 1'b0;
			busy_q  <= 1'b0;
			z_q     <= FLAG_CLR;
			c_q     <= FLAG_CLR;
			hb_q    <= FLAG_CLR;
			to_q    <= TO_RST;
			slp_q   <= SLP_RST;
			wdt_q   <= 1'b0;
			fwe_q   <= 1'b0;
			fwa_q   <= FADDR_RST;
			fwd_q   <= ACC_RST;
		end else begin
			state_q <= state_d;
			acc_q   <= acc_d;
			pc_q    <= pc_d;
			rtn_q   <= rtn_d;
			push_q  <= push_d;
			busy_q  <= busy_d;
			z_q     <= z_d;
			c_q     <= c_d;
			hb_q    <= hb_d;
			to_q    <= to_d;
			slp_q   <= slp_d;
			wdt_q   <= wdt_d;
			fwe_q   <= fwe_d;
			fwa_q   <= fwa_d;
			fwd_q   <= fwd_d;
		end
	end

	// Counter and prescaler share one clear pulse; both live outside
	assign ACC                 = acc_q;
	assign PC                  = pc_q;
	assign STACK_TOP           = rtn_q;
	assign STACK_PUSH          = push_q;
	assign BUSY                = busy_q;
	assign ZERO_FLAG           = z_q;
	assign BORROW_OUT_BIT      = c_q;
	assign HALF_BORROW_BIT     = hb_q;
	assign TIMEOUT_FLAG        = to_q;
	assign SLEEP_FLAG          = slp_q;
	assign WDT_CLEAR           = wdt_q;
	assign WDT_PRESCALER_CLEAR = wdt_q;
	assign FILE_WE             = fwe_q;
	assign FILE_WADDR          = fwa_q;
	assign FILE_WDATA          = fwd_q;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	a_clear_acc_zero: assert property (
		@(posedge CORE_CLK) disable iff (!RST_N)
		take && INSTR_OP == OP_CLEAR_ACC |=> ACC == ACC_ZERO && ZERO_FLAG
			&& $stable(BORROW_OUT_BIT) && $stable(HALF_BORROW_BIT))
		else $error("clear accumulator result or flags wrong");

	a_call_push_next: assert property (
		@(posedge CORE_CLK) disable iff (!RST_N)
		take && INSTR_OP == OP_CALL |=> STACK_PUSH
			&& STACK_TOP == PC_W'($past(PC) + PC_STEP))
		else $error("call pushed wrong return address");

	a_call_pc_target: assert property (
		@(posedge CORE_CLK) disable iff (!RST_N)
		take && INSTR_OP == OP_CALL |=> PC == {$past(PC_UPPER_LATCH[LATCH_HI:LATCH_LO]),
			$past(INSTR_TARGET)})
		else $error("call target not loaded");

	a_call_two_cycles: assert property (
		@(posedge CORE_CLK) disable iff (!RST_N)
		take && INSTR_OP == OP_CALL |=> BUSY && $stable(ZERO_FLAG)
			&& $stable(BORROW_OUT_BIT) ##1 !BUSY && $stable(PC) && $stable(ZERO_FLAG))
		else $error("call did not take exactly two cycles");

	a_kick_clears_wdt: assert property (
		@(posedge CORE_CLK) disable iff (!RST_N)
		WDT_CLEAR |-> WDT_PRESCALER_CLEAR && $past(take && INSTR_OP == OP_KICK_WDT))
		else $error("watchdog clear without kick");

	a_kick_sets_flags: assert property (
		@(posedge CORE_CLK) disable iff (!RST_N)
		take && INSTR_OP == OP_KICK_WDT |=> WDT_CLEAR && TIMEOUT_FLAG && SLEEP_FLAG
			&& $stable(ZERO_FLAG) && $stable(BORROW_OUT_BIT))
		else $error("kick did not set timeout and sleep");

	a_lit_sub_value: assert property (
		@(posedge CORE_CLK) disable iff (!RST_N)
		take && INSTR_OP == OP_LIT_MINUS |=> ACC == ACC_W'($past(INSTR_LIT) - $past(ACC))
			&& ZERO_FLAG == (ACC == ACC_ZERO))
		else $error("literal subtract wrong");

	a_lit_xor_value: assert property (
		@(posedge CORE_CLK) disable iff (!RST_N)
		take && INSTR_OP == OP_LIT_XOR |=> ACC == ($past(INSTR_LIT) ^ $past(ACC))
			&& $stable(BORROW_OUT_BIT) && $stable(HALF_BORROW_BIT))
		else $error("literal xor wrong");

	a_reg_dest_file: assert property (
		@(posedge CORE_CLK) disable iff (!RST_N)
		take && INSTR_OP == OP_REG_XOR && INSTR_DEST == DEST_FILE |=> FILE_WE
			&& FILE_WADDR == $past(INSTR_FADDR) && $stable(ACC)
			&& FILE_WDATA == ($past(FILE_RDATA) ^ $past(ACC)))
		else $error("file destination not honoured");

	a_swap_no_flags: assert property (
		@(posedge CORE_CLK) disable iff (!RST_N)
		take && INSTR_OP == OP_NIBBLE_SWAP && INSTR_DEST != DEST_FILE |=>
			ACC == {$past(FILE_RDATA[NIB_W-1:0]), $past(FILE_RDATA[ACC_W-1:NIB_W])}
			&& $stable(ZERO_FLAG) && $stable(BORROW_OUT_BIT))
		else $error("nibble swap wrong");

	a_borrow_sense: assert property (
		@(posedge CORE_CLK) disable iff (!RST_N)
		take && INSTR_OP == OP_REG_MINUS |=>
			BORROW_OUT_BIT == ($past(FILE_RDATA) >= $past(ACC)))
		else $error("borrow sense wrong");

endmodule

`default_nettype wire

/* cise_pkg.sv */
// Constants and types shared by the instruction-subset execution core.
// Assumes a single 10 MHz clock domain and no register bus.
package cise_pkg;

	// ----------------------------------------
	// Widths
	// ----------------------------------------
	localparam int ACC_W   = 8;
	localparam int PC_W    = 13;
	localparam int TGT_W   = 11;
	localparam int FADDR_W = 7;
	localparam int LATCH_W = 8;
	localparam int NIB_W   = 4;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int LATCH_HI = 4;
	localparam int LATCH_LO = 3;

	// ----------------------------------------
	// Reset values and constants
	// ----------------------------------------
	localparam logic [ACC_W-1:0]   ACC_RST   = 8'h00;
	localparam logic [ACC_W-1:0]   ACC_ZERO  = 8'h00;
	localparam logic [PC_W-1:0]    PC_RST    = 13'h0000;
	localparam logic [PC_W-1:0]    PC_STEP   = 13'h0001;
	localparam logic [FADDR_W-1:0] FADDR_RST = 7'h00;
	localparam logic               FLAG_CLR  = 1'b0;
	localparam logic               TO_RST    = 1'b1;
	localparam logic               SLP_RST   = 1'b1;
	localparam logic               DEST_FILE = 1'b1;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [3:0] {
		OP_NOP,
		OP_CLEAR_ACC,
		OP_CALL,
		OP_KICK_WDT,
		OP_LIT_MINUS,
		OP_LIT_XOR,
		OP_REG_MINUS,
		OP_REG_XOR,
		OP_NIBBLE_SWAP
	} cise_op_e;

	typedef enum logic {
		ST_EXEC,
		ST_CALL2
	} cise_state_e;

endpackage

/* tb_cise_core.sv */
// Self-checking bench for the instruction-subset execution core.
// Assumes the core is driven directly at its ports, one clock, no partner model.
`timescale 1ns/10ps
`default_nettype none

module tb_cise_core
	import cise_pkg::*;
;
	typedef struct packed {
		logic [ACC_W-1:0]   acc;
		logic [PC_W-1:0]    pc;
		logic [PC_W-1:0]    st;
		logic               push, busy, z, c, hb, to, sl, wdt, fwe;
		logic [FADDR_W-1:0] fwa;
		logic [ACC_W-1:0]   fwd;
	} cise_exp_s;

	logic CORE_CLK = 1'b0, RST_N = 1'b0, INSTR_VALID = 1'b0, INSTR_DEST = 1'b0;
	cise_op_e             INSTR_OP = OP_NOP;
	logic [ACC_W-1:0]     INSTR_LIT = 8'h00, FILE_RDATA = 8'h00, ACC, FILE_WDATA;
	logic [TGT_W-1:0]     INSTR_TARGET = 11'h000;
	logic [FADDR_W-1:0]   INSTR_FADDR = 7'h00, FILE_WADDR;
	logic [LATCH_W-1:0]   PC_UPPER_LATCH = 8'h00;
	logic [PC_W-1:0]      PC, STACK_TOP;
	logic                 STACK_PUSH, BUSY, ZERO_FLAG, BORROW_OUT_BIT, HALF_BORROW_BIT;
	logic                 TIMEOUT_FLAG, SLEEP_FLAG, WDT_CLEAR, WDT_PRESCALER_CLEAR, FILE_WE;
	cise_exp_s            m, note, q[$];
	int                   fails = 0, n_checks = 0;
	logic [31:0]          seed = 32'hf869, r1, r2;

	cise_core i_cise_core (.CORE_CLK(CORE_CLK), .RST_N(RST_N), .INSTR_VALID(INSTR_VALID),
		.INSTR_OP(INSTR_OP), .INSTR_LIT(INSTR_LIT), .INSTR_TARGET(INSTR_TARGET),
		.INSTR_FADDR(INSTR_FADDR), .INSTR_DEST(INSTR_DEST), .FILE_RDATA(FILE_RDATA),
		.PC_UPPER_LATCH(PC_UPPER_LATCH), .ACC(ACC), .PC(PC), .STACK_TOP(STACK_TOP),
		.STACK_PUSH(STACK_PUSH), .BUSY(BUSY), .ZERO_FLAG(ZERO_FLAG),
		.BORROW_OUT_BIT(BORROW_OUT_BIT), .HALF_BORROW_BIT(HALF_BORROW_BIT),
		.TIMEOUT_FLAG(TIMEOUT_FLAG), .SLEEP_FLAG(SLEEP_FLAG), .WDT_CLEAR(WDT_CLEAR),
		.WDT_PRESCALER_CLEAR(WDT_PRESCALER_CLEAR), .FILE_WE(FILE_WE),
		.FILE_WADDR(FILE_WADDR), .FILE_WDATA(FILE_WDATA));

	always #50 CORE_CLK = ~CORE_CLK;

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			fails++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic end_sim();
		$display("Counts: %0d checks, %0d mismatches", n_checks, fails);
		if (fails == 0 && n_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// Offer without a note: only for the busy cycle, where it must be ignored
	task automatic offer(input cise_op_e op, input logic [7:0] lit, input logic [7:0] fd,
		input logic d, input logic [6:0] fa, input logic [10:0] tg, input logic [7:0] lt);
		INSTR_VALID = 1'b1;
		INSTR_OP = op;
		INSTR_LIT = lit;
		FILE_RDATA = fd;
		INSTR_DEST = d;
		INSTR_FADDR = fa;
		INSTR_TARGET = tg;
		PC_UPPER_LATCH = lt;
		@(posedge CORE_CLK);
		#1;
	endtask

	task automatic issue(input cise_op_e op, input logic [7:0] lit, input logic [7:0] fd,
		input logic d, input logic [6:0] fa, input logic [10:0] tg, input logic [7:0] lt);
		logic [7:0] a, res;
		logic       wr, lop;
		cise_exp_s  e;
		lop = (op == OP_LIT_MINUS) || (op == OP_LIT_XOR);
		a = lop ? lit : fd;
		e = m;
		e.push = 1'b0;
		e.busy = 1'b0;
		e.wdt = 1'b0;
		e.fwe = 1'b0;
		e.pc = m.pc + PC_STEP;
		wr = 1'b0;
		res = 8'h00;
		case (op)
			OP_CLEAR_ACC: begin e.acc = ACC_ZERO; e.z = 1'b1; end
			OP_CALL: begin
				e.st = m.pc + PC_STEP;
				e.pc = {lt[LATCH_HI:LATCH_LO], tg};
				e.push = 1'b1;
				e.busy = 1'b1;
			end
			OP_KICK_WDT: begin e.wdt = 1'b1; e.to = 1'b1; e.sl = 1'b1; end
			OP_LIT_MINUS, OP_REG_MINUS: begin
				res = a - m.acc;
				e.c = a >= m.acc;
				e.hb = a[3:0] >= m.acc[3:0];
				e.z = res == 8'h00;
				wr = 1'b1;
			end
			OP_LIT_XOR, OP_REG_XOR: begin res = a ^ m.acc; e.z = res == 8'h00; wr = 1'b1; end
			OP_NIBBLE_SWAP: begin res = {fd[3:0], fd[7:4]}; wr = 1'b1; end
			default: ;
		endcase
		if (wr && (lop || d == 1'b0)) e.acc = res;
		else if (wr) begin e.fwe = 1'b1; e.fwa = fa; e.fwd = res; end
		m = e;
		q.push_back(e);
		offer(op, lit, fd, d, fa, tg, lt);
	endtask

	task automatic do_reset();
		INSTR_VALID = 1'b0;
		// Let the last result be checked before the outputs are cleared
		if (RST_N === 1'b1) begin
			@(posedge CORE_CLK);
			#1;
		end
		RST_N = 1'b0;
		repeat (4) @(posedge CORE_CLK);
		#1 RST_N = 1'b1;
		m = '0;
		m.to = TO_RST;
		m.sl = SLP_RST;
		chk(16'(PC), 16'(PC_RST));
		chk(16'(ACC), 16'(ACC_RST));
		chk(16'({TIMEOUT_FLAG, SLEEP_FLAG, ZERO_FLAG, BUSY, FILE_WE}), 16'(5'h18));
	endtask

	// ----------------------------------------
	// Output watcher
	// ----------------------------------------
	// Inputs change 1 ns after the edge, so the edge sees the offered instruction
	always @(posedge CORE_CLK) begin
		if (RST_N === 1'b1 && INSTR_VALID === 1'b1 && BUSY === 1'b0) begin
			#5;
			if (q.size() == 0) begin
				fails++;
				$display("Error at %0t: result with no note", $time);
			end else begin
				note = q.pop_front();
				chk(16'(ACC), 16'(note.acc));
				chk(16'(PC), 16'(note.pc));
				chk(16'(STACK_TOP), 16'(note.st));
				chk(16'({STACK_PUSH, BUSY}), 16'({note.push, note.busy}));
				chk(16'({ZERO_FLAG, BORROW_OUT_BIT, HALF_BORROW_BIT}),
					16'({note.z, note.c, note.hb}));
				chk(16'({TIMEOUT_FLAG, SLEEP_FLAG}), 16'({note.to, note.sl}));
				chk(16'({WDT_CLEAR, WDT_PRESCALER_CLEAR}), 16'({2{note.wdt}}));
				chk({FILE_WE, FILE_WADDR, FILE_WDATA},
					{note.fwe, note.fwa, note.fwd});
			end
		end
	end

	initial begin
		#2000000;
		fails++;
		end_sim();
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		do_reset();
		$display("Test reset done");
		// Equal operands, borrow, halves, both destinations
		issue(OP_LIT_XOR, 8'h5A, 8'h00, 1'b0, 7'h00, 11'h000, 8'h00);
		issue(OP_LIT_MINUS, 8'h5A, 8'h00, 1'b0, 7'h00, 11'h000, 8'h00);
		issue(OP_CLEAR_ACC, 8'h00, 8'h00, 1'b0, 7'h00, 11'h000, 8'h00);
		issue(OP_LIT_XOR, 8'h01, 8'h00, 1'b0, 7'h00, 11'h000, 8'h00);
		issue(OP_REG_MINUS, 8'h00, 8'h00, 1'b1, 7'h7F, 11'h000, 8'h00);
		issue(OP_REG_XOR, 8'h00, 8'hFF, 1'b0, 7'h11, 11'h000, 8'h00);
		issue(OP_LIT_MINUS, 8'h10, 8'h00, 1'b0, 7'h00, 11'h000, 8'h00);
		issue(OP_NIBBLE_SWAP, 8'h00, 8'h3C, 1'b0, 7'h22, 11'h000, 8'h00);
		issue(OP_NIBBLE_SWAP, 8'h00, 8'hA5, 1'b1, 7'h33, 11'h000, 8'h00);
		issue(OP_REG_XOR, 8'h00, 8'hC3, 1'b1, 7'h44, 11'h000, 8'h00);
		issue(OP_KICK_WDT, 8'h00, 8'h00, 1'b0, 7'h00, 11'h000, 8'h00);
		$display("Test arithmetic done");
		// Widest target, then a return address that wraps
		issue(OP_CALL, 8'h00, 8'h00, 1'b0, 7'h00, 11'h7FF, 8'h18);
		offer(OP_CLEAR_ACC, 8'h00, 8'h00, 1'b0, 7'h00, 11'h000, 8'h00);
		issue(OP_CALL, 8'h00, 8'h00, 1'b0, 7'h00, 11'h000, 8'hE7);
		offer(OP_CALL, 8'h00, 8'h00, 1'b0, 7'h00, 11'h123, 8'h08);
		issue(OP_NOP, 8'h00, 8'h00, 1'b0, 7'h00, 11'h000, 8'h00);
		$display("Test call done");
		for (int i = 0; i < 300; i++) begin
			r1 = $random(seed);
			r2 = $random(seed);
			issue(cise_op_e'(4'(r1[7:0] % 9)), r1[15:8], r1[23:16], r1[24], r1[31:25],
				r2[10:0], r2[18:11]);
			if (BUSY === 1'b1) offer(cise_op_e'(4'(r2[23:20] % 9)), r2[31:24], r1[7:0],
				r2[19], r1[30:24], r2[10:0], r2[18:11]);
		end
		$display("Test random done");
		do_reset();
		issue(OP_LIT_MINUS, 8'h00, 8'h00, 1'b0, 7'h00, 11'h000, 8'h00);
		INSTR_VALID = 1'b0;
		repeat (3) @(posedge CORE_CLK);
		chk(16'(q.size()), 16'h0000);
		$display("Test second reset done");
		end_sim();
	end
endmodule

`default_nettype wire
